// ---- sdr_pkg.sv ----
// Shared constants for the flash reset-capability link and both of its ends
package sdr_pkg;
  // Top dword of the discovery table, field by field
  localparam logic [7:0] ENTER4B_FIELD = 8'h80;
  localparam logic [9:0] EXIT4B_FIELD = 10'h300;
  localparam logic [5:0] RESCUE_FIELD = 6'h30;
  localparam logic RFU7_FIELD = 1'h1;
  localparam logic [6:0] SR1_CAPS_FIELD = 7'h68;
  localparam logic [31:0] DW16_VALUE = {ENTER4B_FIELD, EXIT4B_FIELD,
                                        RESCUE_FIELD, RFU7_FIELD,
                                        SR1_CAPS_FIELD};
  // Instruction codes
  localparam logic [7:0] OPC_WREN = 8'h06;
  localparam logic [7:0] OPC_VWREN = 8'h50;
  localparam logic [7:0] OPC_WRSR = 8'h01;
  localparam logic [7:0] OPC_RDSR = 8'h05;
  localparam logic [7:0] OPC_RSTEN = 8'h66;
  localparam logic [7:0] OPC_RST = 8'h99;
  localparam logic [7:0] OPC_QUAD_ON = 8'h38;
  localparam logic [7:0] OPC_QUAD_OFF = 8'hFF;
  // Status register 1 layout and factory content
  localparam logic [7:0] SR1_NV_MASK = 8'hFC;
  localparam logic [7:0] NV_SR1_RESET = 8'h00;
  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int T_RST_NS = 10000;
  localparam int RST_CYCLES = (T_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [9:0] RST_CNT_LOAD = 10'(RST_CYCLES - 1);
  localparam logic [3:0] XIP_EXIT_CLKS = 4'h8;
  localparam logic [3:0] ALL_ONES4 = 4'hF;
  localparam int HOST_DIV = 4;
  // Host request kinds
  typedef enum logic [1:0] {
    SDR_OP_CMD = 2'h0,
    SDR_OP_WRITE = 2'h1,
    SDR_OP_READ = 2'h2,
    SDR_OP_RESET = 2'h3
  } sdr_op_t;
endpackage

// ---- sdr_link_if.sv ----
// Serial link between the host controller and the flash device end
`timescale 1ns/1ns
interface sdr_link_if;
  logic sclk;
  logic cs_n;
  logic [3:0] h_io_o;
  logic [3:0] h_io_oe;
  logic [3:0] d_io_o;
  logic [3:0] d_io_oe;
  logic [3:0] io;
  // Resolved data lines; an undriven line is pulled high
  assign io = (h_io_oe & h_io_o) | (d_io_oe & d_io_o) |
              ~(h_io_oe | d_io_oe);
  modport host (output sclk, output cs_n, output h_io_o, output h_io_oe,
                input io);
  modport dev (input sclk, input cs_n, input io, output d_io_o,
               output d_io_oe);
endinterface

// ---- sdr_device.sv ----
// Flash device end: command intake, soft reset, status register 1
`timescale 1ns/1ns
// What this block does
// [R1] Advertise no four-byte address entry method
// [R2] Advertise no four-byte address exit method
// [R3] Reset only on enable then reset pair
// [R4] Accept reset pair at current link width
// [R5] Host leaves continuous quad read before reset
// [R6] Power-up loads status from non-volatile copy
// [R7] Non-volatile status write needs prior write-enable
// [R8] Write-enable also activates the volatile status copy
// [R9] Eight all-ones quad clocks leave continuous read
// [R10] Ten microsecond reset, all commands rejected
// [R11] Stray reset ignored; other command clears enable
module sdr_device (
  input wire logic CORE_CLK_I,
  input wire logic RST_I,
  sdr_link_if.dev lnk,
  input wire logic XIP_ENTER_I,
  output logic [31:0] DW16_O,
  output logic [7:0] SR1_O,
  output logic [7:0] NV_SR1_O,
  output logic QUAD_O,
  output logic XIP_O,
  output logic RST_BUSY_O
);
  typedef enum logic [1:0] {
    ST_CMD = 2'b00,
    ST_WDAT = 2'b01,
    ST_RDAT = 2'b11,
    ST_SKIP = 2'b10
  } sdr_dst_t;

  sdr_dst_t st_q;
  logic sclk_q;
  logic [7:0] sh_q;
  logic [3:0] cnt_q;
  logic [3:0] xcnt_q;
  logic [7:0] out_q;
  logic [3:0] io_o_q;
  logic [3:0] io_oe_q;
  logic [7:0] sr1_q;
  logic [7:0] nv_q;
  logic wel_q;
  logic vwel_q;
  logic rst_en_q;
  logic busy_q;
  logic [9:0] rcnt_q;
  logic quad_q;
  logic cont_q;
  logic [31:0] dw16_q;

  // Edge detection on the sampled serial clock
  wire sel = ~lnk.cs_n;
  wire rise = sel & lnk.sclk & ~sclk_q;
  wire fall = sel & ~lnk.sclk & sclk_q;
  // Width of the command phase follows the current mode
  wire [3:0] width = quad_q ? 4'h4 : 4'h1; // [R4]
  wire [7:0] in_byte = quad_q ? {sh_q[3:0], lnk.io} :
                                {sh_q[6:0], lnk.io[0]}; // [R4]
  wire [3:0] cnt_nx = cnt_q + width;
  wire byte_done = rise & (cnt_nx == 4'h8);
  // No opcode is decoded while busy or in continuous read
  wire cmd_done = byte_done & (st_q == ST_CMD) & ~busy_q & ~cont_q; // [R10]
  wire is_wren = cmd_done & (in_byte == sdr_pkg::OPC_WREN);
  wire is_vwren = cmd_done & (in_byte == sdr_pkg::OPC_VWREN);
  wire is_wrsr = cmd_done & (in_byte == sdr_pkg::OPC_WRSR);
  wire is_rdsr = cmd_done & (in_byte == sdr_pkg::OPC_RDSR);
  wire is_rsten = cmd_done & (in_byte == sdr_pkg::OPC_RSTEN);
  wire is_rst = cmd_done & (in_byte == sdr_pkg::OPC_RST);
  wire is_qon = cmd_done & (in_byte == sdr_pkg::OPC_QUAD_ON);
  wire is_qoff = cmd_done & quad_q & (in_byte == sdr_pkg::OPC_QUAD_OFF);
  // Reset fires only when the enable was the previous command
  wire do_reset = is_rst & rst_en_q; // [R3] [R11]
  wire reset_end = busy_q & (rcnt_q == 10'h000);
  wire wr_ok = wel_q | vwel_q; // [R7] [R8]
  wire wdat_done = byte_done & (st_q == ST_WDAT);
  wire [7:0] sr1_new = (in_byte & sdr_pkg::SR1_NV_MASK);
  // Continuous read exit: all ones on all four lines for eight clocks
  wire xip_ones = rise & cont_q & (lnk.io == sdr_pkg::ALL_ONES4);
  wire xip_bad = rise & cont_q & (lnk.io != sdr_pkg::ALL_ONES4);
  wire xip_exit = xip_ones &
                  (xcnt_q == sdr_pkg::XIP_EXIT_CLKS - 4'h1); // [R9]

  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      sclk_q <= 1'b0;
    end else begin
      sclk_q <= lnk.sclk;
    end
  end

  // Frame decoder state
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I || lnk.cs_n) begin
      st_q <= ST_CMD;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
    end else if (rise) begin
      sh_q <= in_byte;
      cnt_q <= byte_done ? 4'h0 : cnt_nx;
      if (xip_bad || (byte_done && st_q == ST_CMD && (busy_q || cont_q))) begin
        st_q <= ST_SKIP; // [R10]
      end else if (is_rdsr) begin
        st_q <= ST_RDAT;
      end else if (is_wrsr && wr_ok) begin
        st_q <= ST_WDAT; // [R7]
      end else if (cmd_done || wdat_done) begin
        st_q <= ST_SKIP;
      end
    end
  end

  // Counter of all-ones clocks during continuous read
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I || lnk.cs_n || xip_bad) begin
      xcnt_q <= 4'h0;
    end else if (xip_ones) begin
      xcnt_q <= xcnt_q + 4'h1;
    end
  end

  // Status read-out: data changes on the falling edge of the clock
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I || lnk.cs_n) begin
      io_o_q <= 4'h0;
      io_oe_q <= 4'h0;
      out_q <= 8'h00;
    end else if (is_rdsr) begin
      out_q <= {sr1_q[7:2], wel_q, busy_q};
    end else if (fall && st_q == ST_RDAT) begin
      if (quad_q) begin
        io_o_q <= out_q[7:4];
        io_oe_q <= 4'hF;
        out_q <= {out_q[3:0], out_q[7:4]};
      end else begin
        io_o_q <= {2'b00, out_q[7], 1'b0};
        io_oe_q <= 4'h2;
        out_q <= {out_q[6:0], out_q[7]};
      end
    end
  end

  // Reset enable latch; any other decoded command drops it
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I || reset_end) begin
      rst_en_q <= 1'b0;
    end else if (cmd_done) begin
      rst_en_q <= is_rsten; // [R3] [R11]
    end
  end

  // Reset timer; the pair is rejected while one is in progress
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      busy_q <= 1'b0;
      rcnt_q <= 10'h000;
    end else if (do_reset) begin
      busy_q <= 1'b1; // [R10]
      rcnt_q <= sdr_pkg::RST_CNT_LOAD;
    end else if (reset_end) begin
      busy_q <= 1'b0;
    end else if (busy_q) begin
      rcnt_q <= rcnt_q - 10'h001;
    end
  end

  // Write enables: one status write consumes them, reset clears them
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I || reset_end) begin
      wel_q <= 1'b0;
      vwel_q <= 1'b0;
    end else if (wdat_done) begin
      wel_q <= 1'b0;
      vwel_q <= 1'b0;
    end else begin
      if (is_wren) begin
        wel_q <= 1'b1; // [R7] [R8]
      end
      if (is_vwren) begin
        vwel_q <= 1'b1;
      end
    end
  end

  // Non-volatile copy survives soft reset; power-up gives factory content
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      nv_q <= sdr_pkg::NV_SR1_RESET;
    end else if (wdat_done && wel_q) begin
      nv_q <= sr1_new; // [R7]
    end
  end

  // Volatile copy drives protection; reloaded from the non-volatile one
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      sr1_q <= sdr_pkg::NV_SR1_RESET; // [R6]
    end else if (reset_end) begin
      sr1_q <= nv_q; // [R6] [R3]
    end else if (wdat_done && wr_ok) begin
      sr1_q <= sr1_new; // [R8]
    end
  end

  // Link width and continuous read mode
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I || reset_end) begin
      quad_q <= 1'b0;
      cont_q <= 1'b0;
    end else begin
      if (is_qon) begin
        quad_q <= 1'b1;
      end else if (is_qoff) begin
        quad_q <= 1'b0;
      end
      // The host must clear this mode before a reset can be decoded
      if (xip_exit) begin
        cont_q <= 1'b0; // [R9] [R5]
      end else if (XIP_ENTER_I && lnk.cs_n) begin
        cont_q <= 1'b1;
      end
    end
  end

  // Capability dword is a fixed pattern held in a register
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      dw16_q <= sdr_pkg::DW16_VALUE; // [R1] [R2] [R3]
    end else begin
      dw16_q <= sdr_pkg::DW16_VALUE;
    end
  end

  assign lnk.d_io_o = io_o_q;
  assign lnk.d_io_oe = io_oe_q;
  assign DW16_O = dw16_q;
  assign SR1_O = {sr1_q[7:2], wel_q, busy_q};
  assign NV_SR1_O = nv_q;
  assign QUAD_O = quad_q;
  assign XIP_O = cont_q;
  assign RST_BUSY_O = busy_q;
endmodule

// ---- sdr_host.sv ----
// Host controller end: frames commands and the soft reset sequence
`timescale 1ns/1ns
module sdr_host #(
  parameter int DIV = sdr_pkg::HOST_DIV
) (
  input wire logic CORE_CLK_I,
  input wire logic RST_I,
  sdr_link_if.host lnk,
  input wire logic REQ_I,
  input wire logic [1:0] OP_I,
  input wire logic [7:0] OPC_I,
  input wire logic [7:0] WDATA_I,
  input wire logic QUAD_I,
  input wire logic XIP_I,
  output logic READY_O,
  output logic DONE_O,
  output logic [7:0] RDATA_O
);
  typedef enum logic [1:0] {
    HS_IDLE = 2'b00,
    HS_GAP = 2'b01,
    HS_SHIFT = 2'b11
  } sdr_hst_t;

  sdr_hst_t st_q;
  logic [7:0] div_q;
  logic sclk_q;
  logic cs_n_q;
  logic [3:0] io_o_q;
  logic [3:0] io_oe_q;
  logic [15:0] tx_q;
  logic [5:0] bl_q;
  logic [5:0] cl_q;
  logic [7:0] rx_q;
  logic fq_q;
  logic quad_q;
  logic ex_q;
  logic [1:0] nq_q;
  logic [15:0] q_q;
  logic wr_q;
  logic rd_q;
  logic ready_q;
  logic done_q;
  logic [7:0] rdata_q;

  wire tick = (div_q == 8'(DIV - 1));
  wire [5:0] w = fq_q ? 6'h04 : 6'h01;
  // Frame set-up for the next queued frame
  wire n_fq = ex_q | quad_q; // [R4] [R9]
  wire [15:0] n_tx = ex_q ? 16'hFFFF : {q_q[15:8], WDATA_I};
  wire [5:0] n_bl = ex_q ? 6'h20 : (wr_q ? 6'h10 : 6'h08);
  wire [5:0] n_rx = (rd_q && !ex_q) ? 6'h08 : 6'h00;
  wire [5:0] n_cl = n_fq ? 6'((n_bl + n_rx) >> 2) : 6'(n_bl + n_rx);
  wire last = (nq_q == 2'h1) && !ex_q;

  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I || st_q == HS_IDLE) begin
      div_q <= 8'h00;
    end else begin
      div_q <= tick ? 8'h00 : div_q + 8'h01;
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      st_q <= HS_IDLE;
      sclk_q <= 1'b0;
      cs_n_q <= 1'b1;
      io_o_q <= 4'h0;
      io_oe_q <= 4'h0;
      tx_q <= 16'h0000;
      bl_q <= 6'h00;
      cl_q <= 6'h00;
      rx_q <= 8'h00;
      fq_q <= 1'b0;
      quad_q <= 1'b0;
      ex_q <= 1'b0;
      nq_q <= 2'h0;
      q_q <= 16'h0000;
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      ready_q <= 1'b1;
      done_q <= 1'b0;
      rdata_q <= 8'h00;
    end else begin
      done_q <= 1'b0;
      case (st_q)
        HS_IDLE: begin
          if (REQ_I) begin
            ready_q <= 1'b0;
            quad_q <= QUAD_I;
            wr_q <= (OP_I == sdr_pkg::SDR_OP_WRITE);
            rd_q <= (OP_I == sdr_pkg::SDR_OP_READ);
            if (OP_I == sdr_pkg::SDR_OP_RESET) begin
              ex_q <= XIP_I; // [R5]
              q_q <= {sdr_pkg::OPC_RSTEN, sdr_pkg::OPC_RST}; // [R3]
              nq_q <= 2'h2;
            end else begin
              ex_q <= 1'b0;
              q_q <= {OPC_I, 8'h00};
              nq_q <= 2'h1;
            end
            st_q <= HS_GAP;
          end
        end
        HS_GAP: begin
          // First bits are set up as chip select falls
          if (tick) begin
            cs_n_q <= 1'b0;
            fq_q <= n_fq;
            io_o_q <= n_fq ? n_tx[15:12] : {3'b000, n_tx[15]};
            io_oe_q <= n_fq ? 4'hF : 4'h1;
            tx_q <= n_fq ? {n_tx[11:0], 4'hF} : {n_tx[14:0], 1'b1};
            bl_q <= n_bl - (n_fq ? 6'h04 : 6'h01);
            cl_q <= n_cl;
            st_q <= HS_SHIFT;
          end
        end
        HS_SHIFT: begin
          if (tick && !sclk_q) begin
            if (cl_q == 6'h00) begin
              cs_n_q <= 1'b1;
              io_oe_q <= 4'h0;
              if (ex_q) begin
                ex_q <= 1'b0;
                st_q <= HS_GAP;
              end else if (last) begin
                nq_q <= 2'h0;
                rdata_q <= rx_q;
                done_q <= 1'b1;
                ready_q <= 1'b1;
                st_q <= HS_IDLE;
              end else begin
                nq_q <= nq_q - 2'h1;
                q_q <= {q_q[7:0], 8'h00};
                wr_q <= 1'b0;
                rd_q <= 1'b0;
                st_q <= HS_GAP;
              end
            end else begin
              sclk_q <= 1'b1;
              cl_q <= cl_q - 6'h01;
              if (io_oe_q == 4'h0) begin
                rx_q <= fq_q ? {rx_q[3:0], lnk.io} : {rx_q[6:0], lnk.io[1]};
              end
            end
          end else if (tick) begin
            sclk_q <= 1'b0;
            if (bl_q != 6'h00) begin
              io_o_q <= fq_q ? tx_q[15:12] : {3'b000, tx_q[15]}; // [R4]
              tx_q <= fq_q ? {tx_q[11:0], 4'hF} : {tx_q[14:0], 1'b1};
              bl_q <= bl_q - w;
            end else begin
              io_oe_q <= 4'h0;
            end
          end
        end
        default: begin
          st_q <= HS_IDLE;
        end
      endcase
    end
  end

  assign lnk.sclk = sclk_q;
  assign lnk.cs_n = cs_n_q;
  assign lnk.h_io_o = io_o_q;
  assign lnk.h_io_oe = io_oe_q;
  assign READY_O = ready_q;
  assign DONE_O = done_q;
  assign RDATA_O = rdata_q;
endmodule

// ---- sdr_link_monitor.sv ----
// Protocol checker for the serial link between the host and device ends
`timescale 1ns/1ns
module sdr_link_monitor (
  input wire logic CORE_CLK_I,
  input wire logic RST_I,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic [3:0] h_io_o,
  input wire logic [3:0] h_io_oe,
  input wire logic [3:0] d_io_o,
  input wire logic [3:0] d_io_oe,
  input wire logic [3:0] io
);
  default clocking cb @(posedge CORE_CLK_I);
  endclocking
  default disable iff (RST_I);
  // Counts assume the host divider of 4 used by the bench
  sequence s_high_phase;
    sclk [*4] ##1 !sclk;
  endsequence
  sequence s_select_gap;
    cs_n [*4];
  endsequence
  property p_clk_idle;
    cs_n && $past(cs_n) |-> !sclk;
  endproperty
  property p_high_phase;
    $rose(sclk) |-> s_high_phase;
  endproperty
  property p_select_gap;
    $rose(cs_n) |-> s_select_gap;
  endproperty
  property p_no_clash;
    (h_io_oe & d_io_oe) == 4'h0;
  endproperty
  property p_host_width;
    h_io_oe inside {4'h0, 4'h1, 4'hF};
  endproperty
  property p_dev_width;
    d_io_oe inside {4'h0, 4'h2, 4'hF};
  endproperty
  property p_host_quiet;
    cs_n && $past(cs_n) |-> h_io_oe == 4'h0;
  endproperty
  property p_dev_release;
    $rose(cs_n) |-> ##[1:3] (d_io_oe == 4'h0);
  endproperty
  property p_data_stable;
    sclk && $past(sclk) && !cs_n |-> $stable(h_io_o) && $stable(h_io_oe);
  endproperty
  a_clk_idle: assert property (p_clk_idle)
    else $error("serial clock high while deselected");
  a_high_phase: assert property (p_high_phase)
    else $error("serial clock high phase has wrong length");
  a_select_gap: assert property (p_select_gap)
    else $error("select gap between frames too short");
  a_no_clash: assert property (p_no_clash)
    else $error("both ends drive one data line");
  a_host_width: assert property (p_host_width)
    else $error("host drives an illegal line set");
  a_dev_width: assert property (p_dev_width)
    else $error("device drives an illegal line set");
  a_host_quiet: assert property (p_host_quiet)
    else $error("host drives data while deselected");
  a_dev_release: assert property (p_dev_release)
    else $error("device keeps driving after deselect");
  a_data_stable: assert property (p_data_stable)
    else $error("host data moved while serial clock high");
endmodule

// ---- sdr_tb_top.sv ----
// Self-checking bench joining the host and device ends over one link
`timescale 1ns/1ns
module sdr_tb_top;
  logic clk;
  logic rst;
  logic req;
  sdr_pkg::sdr_op_t op;
  logic [7:0] opc;
  logic [7:0] wdata;
  logic quad;
  logic xip;
  logic xip_enter;
  logic ready;
  logic done;
  logic [7:0] rdata;
  logic [31:0] dw16;
  logic [7:0] sr1;
  logic [7:0] nv_sr1;
  logic quad_on;
  logic xip_on;
  logic rst_busy;
  int n_fail;
  int compares;
  sdr_link_if lnk ();
  sdr_host sdr_host_inst (.CORE_CLK_I(clk), .RST_I(rst), .lnk(lnk),
    .REQ_I(req), .OP_I(op), .OPC_I(opc), .WDATA_I(wdata), .QUAD_I(quad),
    .XIP_I(xip), .READY_O(ready), .DONE_O(done), .RDATA_O(rdata));
  sdr_device sdr_device_inst (.CORE_CLK_I(clk), .RST_I(rst), .lnk(lnk),
    .XIP_ENTER_I(xip_enter), .DW16_O(dw16), .SR1_O(sr1),
    .NV_SR1_O(nv_sr1), .QUAD_O(quad_on), .XIP_O(xip_on),
    .RST_BUSY_O(rst_busy));
  sdr_link_monitor sdr_link_monitor_inst (.CORE_CLK_I(clk), .RST_I(rst),
    .sclk(lnk.sclk), .cs_n(lnk.cs_n), .h_io_o(lnk.h_io_o),
    .h_io_oe(lnk.h_io_oe), .d_io_o(lnk.d_io_o), .d_io_oe(lnk.d_io_oe),
    .io(lnk.io));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic tally_and_finish();
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Inputs always change one time unit after the rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic host_op(input sdr_pkg::sdr_op_t o, input logic [7:0] c,
                         input logic [7:0] d, input logic q, input logic x);
    int i;
    op = o;
    opc = c;
    wdata = d;
    quad = q;
    xip = x;
    req = 1'b1;
    tick(1);
    req = 1'b0;
    chk(ready, 1'b0);
    for (i = 0; i < 4000 && done !== 1'b1; i++) tick(1);
    if (done !== 1'b1) begin
      chk(done, 1'b1);
      tally_and_finish();
    end
    chk(ready, 1'b1);
    // Done must stand for one cycle only
    tick(1);
    chk(done, 1'b0);
  endtask
  task automatic cmd(input logic [7:0] c, input logic q);
    host_op(sdr_pkg::SDR_OP_CMD, c, 8'h00, q, 1'b0);
  endtask
  // Waits out the reset interval; it must still run well after the pair
  task automatic wait_reset();
    int i;
    tick(850);
    chk(rst_busy, 1'b1);
    for (i = 0; i < 200 && rst_busy !== 1'b0; i++) tick(1);
    chk(rst_busy, 1'b0);
    if (rst_busy !== 1'b0) tally_and_finish();
  endtask
  task automatic t_caps();
    chk(dw16, 32'h80C030E8);
    chk(dw16[31:24], 8'h80);
    chk(dw16[23:14], 10'h300);
    chk(dw16[13:8], 6'h30);
    chk(dw16[6:0], 7'h68);
    $display("t_caps done");
  endtask
  task automatic t_nv_write();
    host_op(sdr_pkg::SDR_OP_WRITE, 8'h01, 8'hA4, 1'b0, 1'b0);
    chk(nv_sr1, 8'h00);
    chk(sr1, 8'h00);
    cmd(8'h06, 1'b0);
    chk(sr1[1], 1'b1);
    host_op(sdr_pkg::SDR_OP_WRITE, 8'h01, 8'hA4, 1'b0, 1'b0);
    chk(nv_sr1, 8'hA4);
    host_op(sdr_pkg::SDR_OP_READ, 8'h05, 8'h00, 1'b0, 1'b0);
    chk(rdata, 8'hA4);
    $display("t_nv_write done");
  endtask
  task automatic t_vol();
    cmd(8'h50, 1'b0);
    host_op(sdr_pkg::SDR_OP_WRITE, 8'h01, 8'h5C, 1'b0, 1'b0);
    chk(sr1, 8'h5C);
    chk(nv_sr1, 8'hA4);
    $display("t_vol done");
  endtask
  task automatic t_stray();
    cmd(8'h99, 1'b0);
    chk(rst_busy, 1'b0);
    cmd(8'h66, 1'b0);
    cmd(8'h05, 1'b0);
    cmd(8'h99, 1'b0);
    chk(rst_busy, 1'b0);
    chk(sr1, 8'h5C);
    $display("t_stray done");
  endtask
  task automatic t_reset();
    host_op(sdr_pkg::SDR_OP_RESET, 8'h00, 8'h00, 1'b0, 1'b0);
    chk(rst_busy, 1'b1);
    cmd(8'h06, 1'b0);
    chk(sr1[1], 1'b0);
    wait_reset();
    chk(sr1, 8'hA4);
    $display("t_reset done");
  endtask
  task automatic t_quad();
    cmd(8'h38, 1'b0);
    chk(quad_on, 1'b1);
    cmd(8'h06, 1'b1);
    chk(sr1[1], 1'b1);
    host_op(sdr_pkg::SDR_OP_RESET, 8'h00, 8'h00, 1'b1, 1'b0);
    chk(rst_busy, 1'b1);
    wait_reset();
    chk(quad_on, 1'b0);
    chk(sr1[1], 1'b0);
    $display("t_quad done");
  endtask
  task automatic t_xip();
    xip_enter = 1'b1;
    tick(1);
    xip_enter = 1'b0;
    tick(1);
    chk(xip_on, 1'b1);
    cmd(8'h06, 1'b0);
    chk(sr1[1], 1'b0);
    host_op(sdr_pkg::SDR_OP_RESET, 8'h00, 8'h00, 1'b0, 1'b1);
    chk(rst_busy, 1'b1);
    wait_reset();
    chk(xip_on, 1'b0);
    $display("t_xip done");
  endtask
  initial begin
    n_fail = 0;
    compares = 0;
    rst = 1'b1;
    req = 1'b0;
    op = sdr_pkg::SDR_OP_CMD;
    opc = 8'h00;
    wdata = 8'h00;
    quad = 1'b0;
    xip = 1'b0;
    xip_enter = 1'b0;
    tick(6);
    rst = 1'b0;
    t_caps();
    t_nv_write();
    t_vol();
    t_stray();
    t_reset();
    t_quad();
    t_xip();
    tally_and_finish();
  end
endmodule
